/* File: rtl/system_tick_timer.sv */
// system tick timer: 24-bit down counter behind an AXI4-Lite register slave
// Operation
// - the counter is 24 bits wide, counts down and reloads at zero.
// - any write to the current count register clears the count to zero.
// - while enabled, count down to zero, reload next cycle, keep counting.
// - the zero-reached flag sets one cycle after the count steps from one to zero.
// - reading the register holding the zero-reached flag clears it.
// - a zero reload value keeps the counter parked at zero.
`timescale 1ns/1ps
module system_tick_timer (
  input wire logic ref_clk_in, // 200 MHz core clock
  input wire logic reset_in, // synchronous reset, active high
  input wire logic [tick_pkg::ADDR_W-1:0] s_axi_awaddr_in, // write address
  input wire logic s_axi_awvalid_in, // write address valid
  output logic s_axi_awready_out, // write address ready
  input wire logic [tick_pkg::DATA_W-1:0] s_axi_wdata_in, // write data
  input wire logic [3:0] s_axi_wstrb_in, // write byte strobes
  input wire logic s_axi_wvalid_in, // write data valid
  output logic s_axi_wready_out, // write data ready
  output logic [1:0] s_axi_bresp_out, // write response
  output logic s_axi_bvalid_out, // write response valid
  input wire logic s_axi_bready_in, // write response ready
  input wire logic [tick_pkg::ADDR_W-1:0] s_axi_araddr_in, // read address
  input wire logic s_axi_arvalid_in, // read address valid
  output logic s_axi_arready_out, // read address ready
  output logic [tick_pkg::DATA_W-1:0] s_axi_rdata_out, // read data
  output logic [1:0] s_axi_rresp_out, // read response
  output logic s_axi_rvalid_out, // read data valid
  input wire logic s_axi_rready_in, // read data ready
  output logic irq_out // level interrupt, zero reached and unmasked
);
  import tick_pkg::*;

  // register map, one aligned 32-bit word each, byte addresses on the bus:
  //   control/status: enable in bit 0 (read/write), zero-reached flag in
  //     bit 16 (read only); any read of this word clears the flag
  //   reload value: bits 23:0, upper byte reads as zero, writes ignored
  //   current count: reads the live count; any write clears it to zero,
  //     whatever data or strobes come with it
  //   interrupt mask: bit 16, same layout as the flag in the status word
  // any other address answers with an error response and has no effect
  //
  // timing seen from the bus: a write takes effect at the edge where both
  // halves are present, the same edge at which the response is raised;
  // a read captures its word at the address edge, so a count read is
  // one cycle old by the time the data is presented
  //
  // limitation: the count is not read coherently with the flag; software
  // that needs both reads the status word first, then the count
  //
  // a count left over from before reset has no meaning; the core clears it,
  // but software should still write the current count before enabling
  //
  // bus behaviour: address and data halves of a write may arrive in either
  // order; whichever comes first is held until its partner shows up, and
  // both readies stay low while a write response waits to be taken, so
  // at most one write is in flight; reads likewise wait for the previous
  // read data to be taken before the next address is accepted
  //
  // interrupt: one level output, high while the sticky flag is set and the
  // mask bit is set; masking hides the flag from the output but does not
  // clear it, so unmasking later raises the interrupt again
  //
  // the flag is raised only by a count stepping from one to zero; a clear
  // through the current count register or a parked counter never raises it
  //
  // after reset: enable, flag, mask and reload are zero, the bus is idle
  // with every ready high, and the first request may come at the next edge

  // the byte-lane merge below and the field layout assume these values
  initial begin
    if (COUNT_W != 24) begin
      $error("system_tick_timer: reload merge is written for a 24-bit count");
    end
    if (DATA_W != 32) begin
      $error("system_tick_timer: register words must be 32 bits");
    end
    if (EN_BIT >= DATA_W || FLAG_BIT >= DATA_W) begin
      $error("system_tick_timer: field position outside the register word");
    end
    if (EN_BIT == FLAG_BIT) begin
      $error("system_tick_timer: enable and flag share a bit");
    end
    if (CTRL_OFFS[1:0] != 2'h0 || RELOAD_OFFS[1:0] != 2'h0 ||
        CURRENT_OFFS[1:0] != 2'h0 || MASK_OFFS[1:0] != 2'h0) begin
      $error("system_tick_timer: register offsets must be word aligned");
    end
  end

  // write holding registers, address and data may come in either order; then write response and read channel registers
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [DATA_W-1:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [DATA_W-1:0] rdata_ff;

  // control and status state; count and zero_hit come from the counter core,
  // which owns the count so that clear, reload and decrement meet in one place
  logic enable_ff;
  logic flag_ff;
  logic mask_ff;
  logic [COUNT_W-1:0] reload_ff;
  logic [COUNT_W-1:0] count;
  logic zero_hit;

  // channel handshakes: one write and one read in flight at a time; the
  // readies are built from flops only, never from the valids, so no
  // combinational path runs from a master's valid back to its ready;
  // the cost is an idle gap between back-to-back transfers
  wire aw_fire = s_axi_awvalid_in & s_axi_awready_out;
  wire w_fire = s_axi_wvalid_in & s_axi_wready_out;
  wire ar_fire = s_axi_arvalid_in & s_axi_arready_out;
  assign s_axi_awready_out = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready_out = ~w_held_ff & ~bvalid_ff;
  assign s_axi_arready_out = ~rvalid_ff;

  // both halves of the write present this cycle, from holding regs or the bus
  wire aw_have = aw_held_ff | aw_fire;
  wire w_have = w_held_ff | w_fire;
  wire wr_go = aw_have & w_have & ~bvalid_ff;
  wire [ADDR_W-1:0] wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr_in;
  wire [DATA_W-1:0] wr_data = w_held_ff ? w_data_ff : s_axi_wdata_in;
  wire [3:0] wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb_in;

  // write address decode; a decode only counts while both halves are present,
  // so a held address never acts on stale data
  wire wr_ctrl = wr_go & (wr_addr == CTRL_OFFS);
  wire wr_reload = wr_go & (wr_addr == RELOAD_OFFS);
  wire wr_current = wr_go & (wr_addr == CURRENT_OFFS);
  wire wr_mask = wr_go & (wr_addr == MASK_OFFS);
  wire wr_hit = wr_ctrl | wr_reload | wr_current | wr_mask;

  // read address decode; only meaningful in the cycle the address is taken,
  // which is also the cycle that clears the flag on a status read
  wire rd_ctrl = ar_fire & (s_axi_araddr_in == CTRL_OFFS);
  wire rd_reload = ar_fire & (s_axi_araddr_in == RELOAD_OFFS);
  wire rd_current = ar_fire & (s_axi_araddr_in == CURRENT_OFFS);
  wire rd_mask = ar_fire & (s_axi_araddr_in == MASK_OFFS);
  wire rd_hit = rd_ctrl | rd_reload | rd_current | rd_mask;

  // status fields placed at their bit positions
  wire [DATA_W-1:0] flag_field = DATA_W'(flag_ff) << FLAG_BIT;
  wire [DATA_W-1:0] enable_field = DATA_W'(enable_ff) << EN_BIT;
  wire [DATA_W-1:0] mask_field = DATA_W'(mask_ff) << FLAG_BIT;

  // read data selection; control word carries enable and the zero-reached flag
  wire [DATA_W-1:0] ctrl_word = flag_field | enable_field;
  wire [DATA_W-1:0] rd_word = rd_ctrl ? ctrl_word :
                              rd_reload ? DATA_W'(reload_ff) :
                              rd_current ? DATA_W'(count) :
                              rd_mask ? mask_field : '0;

  // response codes: unmapped addresses answer an error and change nothing
  wire [1:0] wr_resp = wr_hit ? RESP_OKAY : RESP_SLVERR;
  wire [1:0] rd_resp = rd_hit ? RESP_OKAY : RESP_SLVERR;

  // byte-lane merge for the 24-bit reload register; lane 3 has no storage,
  // so its strobe and data are dropped without an error response
  wire [COUNT_W-1:0] reload_merged = {
    wr_strb[2] ? wr_data[23:16] : reload_ff[23:16],
    wr_strb[1] ? wr_data[15:8] : reload_ff[15:8],
    wr_strb[0] ? wr_data[7:0] : reload_ff[7:0]};
  wire en_lane = wr_strb[EN_BIT/8];
  wire flag_lane = wr_strb[FLAG_BIT/8];

  // flag: a zero hit in the same cycle as the clearing read wins, so no
  // zero crossing is ever lost to a read that raced it
  wire flag_set = zero_hit;
  wire flag_read_clear = rd_ctrl;
  wire nxt_flag = flag_set | (flag_ff & ~flag_read_clear);
  wire nxt_enable = (wr_ctrl & en_lane) ? wr_data[EN_BIT] : enable_ff;
  wire nxt_mask = (wr_mask & flag_lane) ? wr_data[FLAG_BIT] : mask_ff;

  // address half of a write waits here when the data half is late
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (aw_fire & ~wr_go) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr_in;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end
  end

  // data half of a write waits here when the address half is late
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      w_held_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= 4'h0;
    end else if (w_fire & ~wr_go) begin
      w_held_ff <= 1'b1;
      w_data_ff <= s_axi_wdata_in;
      w_strb_ff <= s_axi_wstrb_in;
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end
  end

  // write response; raising it blocks both readies, so one write at a time
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_resp;
    end else if (s_axi_bready_in) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read valid: raised one cycle after the address is taken, held until taken
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rvalid_ff <= 1'b0;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
    end else if (s_axi_rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end

  // read word and code captured with the address, stable while valid stands
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
    end else if (ar_fire) begin
      rresp_ff <= rd_resp;
      rdata_ff <= rd_word;
    end
  end

  // enable bit of the control word
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      enable_ff <= EN_RST;
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  // interrupt mask, same bit position as the flag it gates
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      mask_ff <= MASK_RST;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // sticky zero-reached flag; set and read-clear are resolved in nxt_flag
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      flag_ff <= FLAG_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // reload value, changed only by a write to the reload word
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      reload_ff <= RELOAD_RST;
    end else if (wr_reload) begin
      reload_ff <= reload_merged;
    end
  end

  // counter core; the clear ignores data and strobes on purpose, since any
  // write to the current count must clear it, even one with no strobes set;
  // the core acts on a new enable from the edge after the response rises
  tick_down_counter #(
    .WIDTH(COUNT_W)
  ) u_counter (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .enable_in(enable_ff),
    .clear_in(wr_current),
    .reload_in(reload_ff),
    .count_out(count),
    .zero_hit_out(zero_hit)
  );

  // bus outputs
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign s_axi_rdata_out = rdata_ff;

  // interrupt level follows the sticky flag through the mask; both inputs
  // are flops, so the level is glitch free and drops at the edge that
  // takes the clearing read
  assign irq_out = flag_ff & mask_ff;
endmodule : system_tick_timer

/* File: rtl/tick_down_counter.sv */
// down counter core with clear, reload and zero detection
`timescale 1ns/1ps
module tick_down_counter #(
  parameter int unsigned WIDTH = 24
) (
  input wire logic ref_clk_in, // core clock
  input wire logic reset_in, // synchronous reset, active high
  input wire logic enable_in, // counting enabled
  input wire logic clear_in, // software write to current count
  input wire logic [WIDTH-1:0] reload_in, // reload value
  output logic [WIDTH-1:0] count_out, // current count
  output logic zero_hit_out // one-cycle pulse on a count step from one to zero
);
  import tick_pkg::*;

  initial begin
    if (WIDTH < 2) $error("tick_down_counter: WIDTH must be at least 2");
  end

  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  logic zero_hit_ff;
  logic nxt_zero_hit;
  wire at_zero = (count_ff == '0);

  // clear beats counting; at zero the next step is the reload, zero reload parks it
  always_comb begin
    nxt_count = count_ff;
    nxt_zero_hit = 1'b0;
    if (clear_in) begin
      nxt_count = '0;
    end else if (enable_in) begin
      if (at_zero) begin
        nxt_count = reload_in;
      end else begin
        nxt_count = count_ff - 1'b1;
        nxt_zero_hit = (count_ff == {{(WIDTH-1){1'b0}}, 1'b1});
      end
    end
  end

  // count has no meaning after reset, cleared anyway for clean simulation
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      count_ff <= COUNT_RST[WIDTH-1:0];
      zero_hit_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      zero_hit_ff <= nxt_zero_hit;
    end
  end

  assign count_out = count_ff;
  assign zero_hit_out = zero_hit_ff;
endmodule : tick_down_counter

/* File: rtl/tick_pkg.sv */
// package: register map, field positions and reset values of the tick timer
package tick_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned COUNT_W = 24;
  // byte offsets of the words on the register bus
  localparam logic [ADDR_W-1:0] CTRL_OFFS = 4'h0;
  localparam logic [ADDR_W-1:0] RELOAD_OFFS = 4'h4;
  localparam logic [ADDR_W-1:0] CURRENT_OFFS = 4'h8;
  localparam logic [ADDR_W-1:0] MASK_OFFS = 4'hC;
  // control/status word fields
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned FLAG_BIT = 16;
  // reset values and bus response codes
  localparam logic EN_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic MASK_RST = 1'b0;
  localparam logic [COUNT_W-1:0] RELOAD_RST = 24'h000000;
  localparam logic [COUNT_W-1:0] COUNT_RST = 24'h000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tick_pkg

/* File: verif/testbench.sv */
// testbench: register-level scenarios for the system tick timer
`timescale 1ns/1ps
module testbench;
  import tick_pkg::*;
  logic ref_clk_in = 1'h0;
  logic reset_in = 1'h1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rd, c1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  int num_errors = 0, compares = 0;
  // free-running core clock
  always #2.5 ref_clk_in = ~ref_clk_in;
  system_tick_timer system_tick_timer_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .irq_out(irq));
  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // readies and answers are sampled at the rising edge that takes them,
  // and each channel is released by a non-blocking write at that edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge ref_clk_in);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    @(posedge ref_clk_in);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge ref_clk_in);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : rdr
  task automatic t_reset();
    rdr(CTRL_OFFS); chk("ctrl rst", rd, 32'h0);
    rdr(RELOAD_OFFS); chk("reload rst", rd, 32'h0);
    rdr(MASK_OFFS); chk("mask rst", rd, 32'h0);
    wr(4'h6, 32'h1); chk("unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
    rdr(4'h6); chk("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    chk("unmapped rdata", rd, 32'h0);
  endtask : t_reset
  task automatic t_hold();
    wr(RELOAD_OFFS, 32'hFF000020); rdr(RELOAD_OFFS); chk("reload", rd, 32'h20);
    wr(CURRENT_OFFS, 32'hFFFFFFFF); rdr(CURRENT_OFFS); chk("clear", rd, 32'h0);
    repeat (10) @(posedge ref_clk_in);
    rdr(CURRENT_OFFS); chk("idle hold", rd, 32'h0);
  endtask : t_hold
  task automatic t_count();
    wr(MASK_OFFS, 32'h10000); wr(CTRL_OFFS, 32'h1);
    for (int i = 0; i < 200 && irq !== 1'h1; i++) @(posedge ref_clk_in);
    chk("irq set", irq, 1'h1);
    rdr(CURRENT_OFFS); chk("reloaded", rd <= 32'h20 && rd >= 32'h18, 1'h1);
    rdr(CTRL_OFFS); chk("flag", rd, 32'h10001);
    rdr(CTRL_OFFS); chk("flag cleared", rd, 32'h1);
    chk("irq cleared", irq, 1'h0);
    wr(CTRL_OFFS, 32'h0); rdr(CURRENT_OFFS); c1 = rd;
    repeat (40) @(posedge ref_clk_in);
    rdr(CURRENT_OFFS); chk("stop hold", rd, c1);
    rdr(CTRL_OFFS); chk("stop flag", rd, 32'h0);
    chk("stopped mid count", c1 != 32'h0, 1'h1);
    wr(CURRENT_OFFS, 32'h5A5A5A5A);
    rdr(CURRENT_OFFS); chk("clear mid count", rd, 32'h0);
    rdr(CTRL_OFFS); chk("clear no flag", rd, 32'h0);
  endtask : t_count
  task automatic t_park();
    wr(RELOAD_OFFS, 32'h10); wr(CTRL_OFFS, 32'h1); wr(RELOAD_OFFS, 32'h0);
    repeat (80) @(posedge ref_clk_in);
    chk("irq park", irq, 1'h1);
    wr(MASK_OFFS, 32'h0); chk("irq masked", irq, 1'h0);
    rdr(CTRL_OFFS);
    repeat (40) @(posedge ref_clk_in);
    rdr(CURRENT_OFFS); chk("parked", rd, 32'h0);
    rdr(CTRL_OFFS); chk("park flag", rd, 32'h1);
  endtask : t_park
  // main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge ref_clk_in);
    reset_in <= 1'h0;
    t_reset();
    t_hold();
    t_count();
    t_park();
    close_out();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    num_errors++;
    close_out();
  end
endmodule : testbench

/* File: verif/tick_checker.sv */
// checker: bus handshake and interrupt relations at the tick timer ports
`timescale 1ns/1ps
module tick_checker (
  input wire logic ref_clk_in, // core clock
  input wire logic reset_in, // sync reset
  input wire logic s_axi_arvalid_in, // read address valid
  input wire logic s_axi_arready_out, // read address ready
  input wire logic s_axi_rvalid_out, // read valid
  input wire logic s_axi_rready_in, // read ready
  input wire logic [31:0] s_axi_rdata_out, // read data
  input wire logic s_axi_bvalid_out, // write response valid
  input wire logic s_axi_bready_in, // write response ready
  input wire logic [1:0] s_axi_bresp_out, // write response
  input wire logic irq_out // interrupt
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // read channel: answer one edge after the address, held until taken
  sequence s_ar_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  property p_read_answer;
    s_ar_taken |=> s_axi_rvalid_out;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_r_drop;
    s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read valid stuck");
  property p_ar_block;
    s_axi_rvalid_out |-> !s_axi_arready_out;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("address taken during read data");
  // write response held until taken, then released
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_b_drop;
    s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response stuck");
  // reset clears the flag, so the interrupt is low just after it
  property p_irq_reset;
    disable iff (1'h0) reset_in |=> !irq_out;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("interrupt high after reset");
endmodule : tick_checker
bind system_tick_timer tick_checker tick_checker_inst (.ref_clk_in, .reset_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in,
  .s_axi_rdata_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .irq_out);
